// file: include/ccid_map.vh
`ifndef CCID_MAP_VH
`define CCID_MAP_VH

// Register byte offsets on the slave bus
`define CCID_OFS_CTRL   5'h00
`define CCID_OFS_STAT   5'h04
`define CCID_OFS_WREG   5'h08
`define CCID_OFS_PTR0   5'h0c
`define CCID_OFS_PTR1   5'h10
`define CCID_OFS_PC     5'h14
`define CCID_OFS_PCHI   5'h18
`define CCID_OFS_CYC    5'h1c

// Status and control register field positions
`define CCID_ST_C       0
`define CCID_ST_DC      1
`define CCID_ST_Z       2
`define CCID_ST_PD      3
`define CCID_ST_TO      4
`define CCID_ST_GIE     5
`define CCID_ST_SLEEP   6
`define CCID_CTRL_RUN   0

// Reset values
`define CCID_RST_RUN    1'h0
`define CCID_RST_FLAG   1'h1

// Exact inherent and control words
`define CCID_OP_NOP     14'h0000
`define CCID_OP_RESET   14'h0001
`define CCID_OP_RETURN  14'h0008
`define CCID_OP_INTERRUPT_RETURN_OP  14'h0009
`define CCID_OP_CALL_BY_WORKING_OP   14'h000a
`define CCID_OP_BRW     14'h000b
`define CCID_OP_SLEEP   14'h0063
`define CCID_OP_WATCHDOG_CLEAR_OP  14'h0064

// Opcode prefixes, compared against the top bits
`define CCID_PF_PIN_DIRECTION_LOAD_OP    11'h00c
`define CCID_PF_MM      10'h001
`define CCID_PF_REGISTER_ADD_OP   6'h07
`define CCID_PF_CALL    3'h4
`define CCID_PF_GOTO    3'h5
`define CCID_PF_BRA     5'h19
`define CCID_PF_POINTER_ADD_LITERAL_OP  7'h62
`define CCID_PF_RETURN_WITH_LITERAL_OP   6'h34
`define CCID_PF_LITERAL_AND_OP   6'h39
`define CCID_PF_LITERAL_ADD_OP   6'h3e
`define CCID_PF_IDX     6'h3f

// Pointer step for inc/dec modes
`define CCID_STEP_UP    16'h0001
`define CCID_STEP_DN    16'hffff

// Core states
`define CCID_S_FETCH    3'h0
`define CCID_S_DECODE   3'h1
`define CCID_S_MEM      3'h2
`define CCID_S_END      3'h3
`define CCID_S_SLEEP    3'h4

`endif

// file: src/ccid_alu.v
`default_nettype none
module ccid_alu (
	// Operands
	input  wire [7:0] a,
	input  wire [7:0] b,
	input  wire       and_sel,
	// Result and flags
	output wire [7:0] y,
	output wire       c,
	output wire       dc,
	output wire       z
);
	wire [8:0] sum;
	wire [4:0] low;

	// Full and low-nibble sums for carry and digit carry
	assign sum = {1'b0, a} + {1'b0, b};
	assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};

	// AND leaves carries meaningless; caller ignores them
	assign y  = and_sel ? (a & b) : sum[7:0];
	assign c  = sum[8];
	assign dc = low[4];
	assign z  = (y == 8'h00);
endmodule // ccid_alu
`default_nettype wire

// file: src/ccid_core.v
// Function
// (RL1) PC change or true test: two cycles
// (RL2) Indirect with pointer MSb set: extra cycle
// (RL3) Branch by working register, two cycles
// (RL4) Call by working register, pushes return
// (RL5) Interrupt return pops PC, two cycles
// (RL6) Return with literal loads working register
// (RL7) Subroutine return pops PC, two cycles
// (RL8) Watchdog clear, one cycle, sets flags
// (RL9) Software reset instruction, one cycle
// (RL10) Sleep enters standby, updates flags
// (RL11) Load pin direction from working register
// (RL12) Pointer add literal, no flags change
// (RL13) Literal signed six bits, 16-bit pointer
// (RL14) Pointer arithmetic wraps modulo 16 bits
// (RL15) Indirect read with modes, zero flag
// (RL16) Indirect write with modes, no flags
// (RL17) Indexed indirect read, zero flag
// (RL18) Indexed indirect write, no flags
// (RL19) Literal AND into W, zero only
// (RL20) Literal add: carry, digit carry, zero
// (RL21) Register add, destination bit selects
// (RL22) Branch nine bits, jumps eleven, NOP
`include "ccid_map.vh"
`default_nettype none
module ccid_core #(
	parameter STACK_D = 16,
	parameter SP_W    = 4
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// Avalon-MM slave
	input  wire [4:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Program memory, asynchronous read
	output reg  [14:0] prog_addr_r,
	input  wire [13:0] prog_data,
	// Data memory, asynchronous read
	output reg  [15:0] data_addr_r,
	output reg  [7:0]  data_wdata_r,
	output reg         data_we_r,
	output reg         data_re_r,
	input  wire [7:0]  data_rdata,
	// System events
	input  wire        wake_pin,
	output reg         soft_reset_r,
	output reg         watchdog_clear_r,
	output reg         sleep_r,
	// Pin direction load
	output reg         pin_dir_we_r,
	output reg  [2:0]  pin_dir_sel_r,
	output reg  [7:0]  pin_dir_data_r,
	// Retire report
	output reg         retire_r,
	output reg  [1:0]  retire_cycles_r
);
	reg  [7:0]  w_r;
	reg  [15:0] fsr0_r;
	reg  [15:0] fsr1_r;
	reg  [14:0] pc_r;
	reg  [6:0]  pclath_r;
	reg         c_r;
	reg         dc_r;
	reg         z_r;
	reg         to_r;
	reg         pd_r;
	reg         gie_r;
	reg         run_r;
	reg  [2:0]  state_r;
	reg  [13:0] ir_r;
	reg  [1:0]  nop_cnt_r;
	reg  [1:0]  cyc_r;
	reg  [15:0] retire_cnt_r;
	reg  [SP_W-1:0] sp_r;
	reg  [14:0] stk_r [0:STACK_D-1];
	reg         wk1_r;
	reg         wk2_r;
	reg         wk3_r;
	reg         wake_lvl_r;
	reg  [31:0] rd_mux;

	wire [13:0] op;
	wire        in_dec;
	wire        bus_req;
	wire        bus_wr;
	wire [14:0] pc_inc;
	wire [14:0] pop_pc;
	wire        is_pin_direction_load_op;
	wire        is_mm;
	wire        is_idx;
	wire        is_register_add_op;
	wire        is_call;
	wire        is_call_by_working_op;
	wire        mem_rd;
	wire        ptr_n;
	wire [15:0] ptr_cur;
	wire [15:0] k6_ext;
	wire [15:0] ptr_step;
	wire [15:0] ptr_upd;
	wire [15:0] mm_addr;
	wire [15:0] idx_addr;
	wire [7:0]  alu_b;
	wire [7:0]  alu_y;
	wire        alu_c;
	wire        alu_dc;
	wire        alu_z;

	// Instruction word: live from memory in decode, held after
	assign in_dec  = (state_r == `CCID_S_DECODE);
	assign op      = in_dec ? prog_data : ir_r;
	assign bus_req = avs_read | avs_write;
	assign bus_wr  = avs_write & ~avs_waitrequest;
	assign pc_inc  = pc_r + 15'h0001;
	assign pop_pc  = stk_r[sp_r - 1'b1];

	// Opcode classes
	assign is_pin_direction_load_op  = (op[13:3] == `CCID_PF_PIN_DIRECTION_LOAD_OP);
	assign is_mm    = (op[13:4] == `CCID_PF_MM);
	assign is_idx   = (op[13:8] == `CCID_PF_IDX);
	assign is_register_add_op = (op[13:8] == `CCID_PF_REGISTER_ADD_OP);
	assign is_call  = (op[13:11] == `CCID_PF_CALL);
	assign is_call_by_working_op = (op == `CCID_OP_CALL_BY_WORKING_OP);
	assign mem_rd   = (is_mm & ~op[3]) | (is_idx & ~op[7]);

	// Pointer select: n sits in a different bit per form
	assign ptr_n   = is_mm ? op[2] : (is_register_add_op ? op[0] : op[6]);
	assign ptr_cur = ptr_n ? fsr1_r : fsr0_r;
	// RL13 signed six-bit literal
	assign k6_ext  = {{10{op[5]}}, op[5:0]};
	assign ptr_step = op[0] ? `CCID_STEP_DN : `CCID_STEP_UP;
	// RL14 wraps by width
	assign ptr_upd  = ptr_cur + ptr_step;
	assign idx_addr = ptr_cur + k6_ext;
	// Post modes address with the old pointer
	assign mm_addr  = op[1] ? ptr_cur : ptr_upd;

	// Literal operand in decode, file operand in memory phase
	assign alu_b = in_dec ? op[7:0] : data_rdata;

	ccid_alu u_alu (
		.a       (w_r),
		.b       (alu_b),
		.and_sel (op[13:8] == `CCID_PF_LITERAL_AND_OP),
		.y       (alu_y),
		.c       (alu_c),
		.dc      (alu_dc),
		.z       (alu_z)
	);

	// Wake pin synchroniser; change accepted when stages agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wk1_r      <= 1'b0;
			wk2_r      <= 1'b0;
			wk3_r      <= 1'b0;
			wake_lvl_r <= 1'b0;
		end else begin
			wk1_r <= wake_pin;
			wk2_r <= wk1_r;
			wk3_r <= wk2_r;
			if (wk2_r == wk3_r)
				wake_lvl_r <= wk3_r;
		end
	end

	// RL4 return address push
	always @(posedge core_clk) begin
		if (in_dec && !bus_wr && (is_call || is_call_by_working_op))
			stk_r[sp_r] <= pc_inc;
	end

	// Register read view
	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
		`CCID_OFS_CTRL: rd_mux[`CCID_CTRL_RUN] = run_r;
		`CCID_OFS_STAT: rd_mux[6:0] = {sleep_r, gie_r, to_r, pd_r,
			z_r, dc_r, c_r};
		`CCID_OFS_WREG: rd_mux[7:0]  = w_r;
		`CCID_OFS_PTR0: rd_mux[15:0] = fsr0_r;
		`CCID_OFS_PTR1: rd_mux[15:0] = fsr1_r;
		`CCID_OFS_PC:   rd_mux[14:0] = pc_r;
		`CCID_OFS_PCHI: rd_mux[6:0]  = pclath_r;
		`CCID_OFS_CYC:  rd_mux[17:0] = {retire_cycles_r, retire_cnt_r};
		default:        rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answers only while the core is idle, so no write races it
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (bus_req && avs_waitrequest &&
			(state_r == `CCID_S_FETCH || state_r == `CCID_S_SLEEP)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Core sequencer, decode and execute
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_r <= 8'h00;
			fsr0_r <= 16'h0000;
			fsr1_r <= 16'h0000;
			pc_r <= 15'h0000;
			pclath_r <= 7'h00;
			{c_r, dc_r, z_r, gie_r} <= 4'h0;
			to_r <= `CCID_RST_FLAG;
			pd_r <= `CCID_RST_FLAG;
			run_r <= `CCID_RST_RUN;
			state_r <= `CCID_S_FETCH;
			ir_r <= `CCID_OP_NOP;
			nop_cnt_r <= 2'h0;
			cyc_r <= 2'h0;
			retire_cnt_r <= 16'h0000;
			sp_r <= {SP_W{1'b0}};
			prog_addr_r <= 15'h0000;
			data_addr_r <= 16'h0000;
			data_wdata_r <= 8'h00;
			data_we_r <= 1'b0;
			data_re_r <= 1'b0;
			soft_reset_r <= 1'b0;
			watchdog_clear_r <= 1'b0;
			sleep_r <= 1'b0;
			pin_dir_we_r <= 1'b0;
			pin_dir_sel_r <= 3'h0;
			pin_dir_data_r <= 8'h00;
			retire_r <= 1'b0;
			retire_cycles_r <= 2'h0;
		end else begin
			data_we_r <= 1'b0;
			data_re_r <= 1'b0;
			soft_reset_r <= 1'b0;
			watchdog_clear_r <= 1'b0;
			pin_dir_we_r <= 1'b0;
			retire_r <= 1'b0;
			if (bus_wr) begin
				case (avs_address)
				`CCID_OFS_CTRL: run_r <= avs_writedata[`CCID_CTRL_RUN];
				`CCID_OFS_STAT: begin
					c_r   <= avs_writedata[`CCID_ST_C];
					dc_r  <= avs_writedata[`CCID_ST_DC];
					z_r   <= avs_writedata[`CCID_ST_Z];
					gie_r <= avs_writedata[`CCID_ST_GIE];
				end
				`CCID_OFS_WREG: w_r <= avs_writedata[7:0];
				`CCID_OFS_PTR0: fsr0_r <= avs_writedata[15:0];
				`CCID_OFS_PTR1: fsr1_r <= avs_writedata[15:0];
				`CCID_OFS_PCHI: pclath_r <= avs_writedata[6:0];
				default: ;
				endcase
			end else begin
				case (state_r)
				`CCID_S_FETCH: begin
					// Hold off while a bus access is pending
					if (run_r && !bus_req) begin
						prog_addr_r <= pc_r;
						state_r <= `CCID_S_DECODE;
					end
				end
				`CCID_S_DECODE: begin
					ir_r <= op;
					pc_r <= pc_inc;
					nop_cnt_r <= 2'h0;
					cyc_r <= 2'h1;
					state_r <= `CCID_S_END;
					// RL1 control ops take a NOP cycle
					if (op == `CCID_OP_BRW) begin
						// RL3 relative by working
						pc_r <= pc_inc + {7'h00, w_r};
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (is_call_by_working_op) begin
						// RL4 call by working
						pc_r <= {pclath_r, w_r};
						sp_r <= sp_r + 1'b1;
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (op == `CCID_OP_INTERRUPT_RETURN_OP) begin
						// RL5 pop and re-enable
						pc_r <= pop_pc;
						sp_r <= sp_r - 1'b1;
						gie_r <= 1'b1;
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (op[13:8] == `CCID_PF_RETURN_WITH_LITERAL_OP) begin
						// RL6 literal into W
						w_r <= op[7:0];
						pc_r <= pop_pc;
						sp_r <= sp_r - 1'b1;
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (op == `CCID_OP_RETURN) begin
						// RL7 subroutine return
						pc_r <= pop_pc;
						sp_r <= sp_r - 1'b1;
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (op[13:9] == `CCID_PF_BRA) begin
						// RL22 nine-bit signed branch
						pc_r <= pc_inc + {{6{op[8]}}, op[8:0]};
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (is_call ||
						op[13:11] == `CCID_PF_GOTO) begin
						// RL22 eleven-bit target
						pc_r <= {pclath_r[6:3], op[10:0]};
						if (is_call)
							sp_r <= sp_r + 1'b1;
						nop_cnt_r <= 2'h1;
						cyc_r <= 2'h2;
					end else if (op == `CCID_OP_WATCHDOG_CLEAR_OP) begin
						// RL8 watchdog clear
						watchdog_clear_r <= 1'b1;
						to_r <= 1'b1;
						pd_r <= 1'b1;
					end else if (op == `CCID_OP_RESET) begin
						// RL9 registers to reset values; TO, PD and run kept
						soft_reset_r <= 1'b1;
						pc_r <= 15'h0000;
						sp_r <= {SP_W{1'b0}};
						w_r <= 8'h00;
						fsr0_r <= 16'h0000;
						fsr1_r <= 16'h0000;
						pclath_r <= 7'h00;
						{c_r, dc_r, z_r, gie_r} <= 4'h0;
					end else if (op == `CCID_OP_SLEEP) begin
						// RL10 standby until wake
						to_r <= 1'b1;
						pd_r <= 1'b0;
						sleep_r <= 1'b1;
						state_r <= `CCID_S_SLEEP;
					end else if (is_pin_direction_load_op) begin
						// RL11 pin direction load
						pin_dir_we_r <= 1'b1;
						pin_dir_sel_r <= op[2:0];
						pin_dir_data_r <= w_r;
					end else if (op[13:7] == `CCID_PF_POINTER_ADD_LITERAL_OP) begin
						// RL12 pointer add, flags kept
						if (ptr_n)
							fsr1_r <= idx_addr;
						else
							fsr0_r <= idx_addr;
					end else if (op[13:8] == `CCID_PF_LITERAL_AND_OP) begin
						// RL19 AND literal, Z only
						w_r <= alu_y;
						z_r <= alu_z;
					end else if (op[13:8] == `CCID_PF_LITERAL_ADD_OP) begin
						// RL20 add literal, C DC Z
						w_r <= alu_y;
						c_r <= alu_c;
						dc_r <= alu_dc;
						z_r <= alu_z;
					end else if (is_mm || is_idx || is_register_add_op) begin
						state_r <= `CCID_S_MEM;
						data_wdata_r <= w_r;
						data_re_r <= mem_rd | is_register_add_op;
						data_we_r <= ~mem_rd & ~is_register_add_op;
						if (is_mm) begin
							// RL15 RL16 pre/post step
							data_addr_r <= mm_addr;
							if (ptr_n)
								fsr1_r <= ptr_upd;
							else
								fsr0_r <= ptr_upd;
							nop_cnt_r <= {1'b0, mm_addr[15]};
							cyc_r <= 2'h1 + {1'b0, mm_addr[15]};
						end else if (is_idx) begin
							// RL17 RL18 indexed access
							data_addr_r <= idx_addr;
							nop_cnt_r <= {1'b0, idx_addr[15]};
							cyc_r <= 2'h1 + {1'b0, idx_addr[15]};
						end else if (op[6:1] == 6'h00) begin
							// RL2 indirect file operand
							data_addr_r <= ptr_cur;
							nop_cnt_r <= {1'b0, ptr_cur[15]};
							cyc_r <= 2'h1 + {1'b0, ptr_cur[15]};
						end else begin
							data_addr_r <= {9'h000, op[6:0]};
						end
					end
					// Undefined words fall through as one-cycle NOPs
				end
				`CCID_S_MEM: begin
					state_r <= `CCID_S_END;
					if (mem_rd) begin
						// RL15 RL17 load W, zero flag
						w_r <= data_rdata;
						z_r <= (data_rdata == 8'h00);
					end else if (is_register_add_op) begin
						// RL21 add W and f to dest
						c_r <= alu_c;
						dc_r <= alu_dc;
						z_r <= alu_z;
						if (op[7]) begin
							data_we_r <= 1'b1;
							data_wdata_r <= alu_y;
						end else begin
							w_r <= alu_y;
						end
					end
				end
				`CCID_S_END: begin
					// RL1 RL2 burn NOP cycles then retire
					if (nop_cnt_r != 2'h0) begin
						nop_cnt_r <= nop_cnt_r - 2'h1;
					end else begin
						retire_r <= 1'b1;
						retire_cycles_r <= cyc_r;
						retire_cnt_r <= retire_cnt_r + 16'h0001;
						state_r <= `CCID_S_FETCH;
					end
				end
				`CCID_S_SLEEP: begin
					// Limitation: only the wake pin ends standby
					if (wake_lvl_r) begin
						sleep_r <= 1'b0;
						state_r <= `CCID_S_END;
					end
				end
				default: state_r <= `CCID_S_FETCH;
				endcase
			end
		end
	end
endmodule // ccid_core
`default_nettype wire

// file: testbench/ccid_chk_assertions.sv
`default_nettype none
module ccid_chk (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// Register bus
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	// Core events
	input wire logic       data_we_r,
	input wire logic       data_re_r,
	input wire logic       soft_reset_r,
	input wire logic       watchdog_clear_r,
	input wire logic       pin_dir_we_r,
	input wire logic       retire_r,
	input wire logic [1:0] retire_cycles_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Answer strobe is a single cycle
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest held low");
	// Bounded wait; a busy core retires within a few clocks
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[1:8] !avs_waitrequest) else $error("bus never answered");
	a_retire_gap: assert property (retire_r |=> !retire_r [*2])
		else $error("retire too soon");
	a_cycles_set: assert property (retire_r |-> retire_cycles_r != 2'h0)
		else $error("zero cycle count");
	a_wdc_one: assert property (watchdog_clear_r
		|-> ##[0:3] (retire_r && retire_cycles_r == 2'h1))
		else $error("watchdog clear not one cycle");
	a_rst_one: assert property (soft_reset_r
		|-> ##[0:3] (retire_r && retire_cycles_r == 2'h1))
		else $error("soft reset not one cycle");
	a_dir_one: assert property (pin_dir_we_r
		|-> ##[0:3] (retire_r && retire_cycles_r == 2'h1))
		else $error("direction load not one cycle");
	a_we_pulse: assert property (data_we_r |=> !data_we_r)
		else $error("write strobe too long");
	a_rd_wr_apart: assert property (!(data_re_r && data_we_r))
		else $error("read and write together");
endmodule // ccid_chk

bind ccid_core ccid_chk u_chk (.*);
`default_nettype wire

// file: testbench/ccid_mem.sv
`default_nettype none
module ccid_mem (
	// Clock
	input wire logic        core_clk,
	// Program side
	input wire logic [14:0] prog_addr_r,
	output logic     [13:0] prog_data,
	// Data side
	input wire logic [15:0] data_addr_r,
	input wire logic [7:0]  data_wdata_r,
	input wire logic        data_we_r,
	input wire logic        data_re_r,
	output logic     [7:0]  data_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] pm [0:255];
	logic [7:0]  dm [0:255];
	logic        re_d;
	// Small memories, upper address bits ignored
	assign prog_data = pm[prog_addr_r[7:0]];
	// Outside the read window the bus shows garbage, not stale data
	assign data_rdata = (data_re_r | re_d) ? dm[data_addr_r[7:0]]
		: ~dm[data_addr_r[7:0]];
	// Write on strobe, track read window
	always @(posedge core_clk) begin
		re_d <= data_re_r;
		if (data_we_r)
			dm[data_addr_r[7:0]] <= data_wdata_r;
	end
endmodule // ccid_mem
`default_nettype wire

// file: testbench/core_control_indirect_op_decoder_bench.sv
`default_nettype none
module core_control_indirect_op_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 0;
	logic        rst_n = 0;
	logic [4:0]  avs_address = 0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic        wake_pin = 0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [14:0] prog_addr_r;
	logic [13:0] prog_data;
	logic [15:0] data_addr_r;
	logic [7:0]  data_wdata_r, data_rdata, pin_dir_data_r;
	logic        data_we_r, data_re_r, soft_reset_r, watchdog_clear_r;
	logic        sleep_r, pin_dir_we_r, retire_r;
	logic [2:0]  pin_dir_sel_r;
	logic [1:0]  retire_cycles_r;
	logic [31:0] q_rd [$];
	logic [1:0]  q_cyc [$];
	int          n_fail = 0;
	int          n_compared = 0;
	logic [7:0]  w0, k1, k2, v, m30, w2;
	logic [8:0]  t;
	logic [4:0]  h;

	ccid_core u_dut (.*);
	ccid_mem u_mem (.*);

	always #20 core_clk = ~core_clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// One bus cycle; a read notes its expected data first
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		if (!wr)
			q_rd.push_back(d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 0;
		avs_write <= 0;
	endtask

	task test_done;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watch read data and retire counts against the notes
	always @(posedge core_clk) begin
		if (avs_read && avs_waitrequest === 1'b0)
			chk(avs_readdata, q_rd.pop_front());
		if (retire_r === 1'b1 && q_cyc.size() > 0)
			chk({30'h0, retire_cycles_r}, {30'h0, q_cyc.pop_front()});
	end

	// Hang guard, far beyond the expected run
	initial begin
		#(40 * 4000);
		n_fail++;
		test_done();
	end

	initial begin
		void'($urandom(32'hb768));
		{w0, k1, k2, v} = $urandom;
		m30 = 8'($urandom);
		for (int i = 0; i < 256; i++)
			u_mem.pm[i] = 14'h0000;
		u_mem.pm[0] = {6'h3e, k1};
		u_mem.pm[1] = {6'h39, k2};
		u_mem.pm[2] = 14'h3120;
		u_mem.pm[3] = 14'h001a;
		u_mem.pm[4] = 14'h0011;
		u_mem.pm[5] = 14'h3f45;
		u_mem.pm[6] = 14'h07b0;
		u_mem.pm[7] = 14'h0065;
		u_mem.pm[8] = 14'h0064;
		u_mem.pm[9] = 14'h3201;
		u_mem.pm[10] = 14'h0001;
		u_mem.pm[11] = 14'h2014;
		u_mem.pm[13] = 14'h000a;
		u_mem.pm[14] = 14'h280e;
		u_mem.pm[20] = 14'h345a;
		u_mem.pm[90] = 14'h0008;
		u_mem.dm[8'h25] = v;
		u_mem.dm[8'h30] = m30;
		w2 = (w0 + k1) & k2;
		t = {1'b0, v} + {1'b0, m30};
		h = {1'b0, v[3:0]} + {1'b0, m30[3:0]};
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		bus(1, 5'h08, {24'h0, w0});
		bus(1, 5'h0c, 32'h0000_0010);
		bus(1, 5'h10, 32'h0000_0020);
		q_cyc = {2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
		q_cyc = {q_cyc, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2, 2'h2};
		bus(1, 5'h00, 32'h0000_0001);
		for (int i = 0; i < 300 && q_cyc.size() > 0; i++)
			@(posedge core_clk);
		chk(q_cyc.size(), 0);
		bus(1, 5'h00, 32'h0000_0000);
		bus(0, 5'h08, 32'h0000_005a);
		bus(0, 5'h0c, 32'h0000_fff0);
		bus(0, 5'h10, 32'h0000_0020);
		bus(1, 5'h14, 32'h0000_0000);
		bus(0, 5'h14, 32'h0000_000e);
		bus(0, 5'h04, {27'h0, 2'b11, t[7:0] == 8'h00, h[4], t[8]});
		bus(0, 5'h1e, 32'h0000_0000);
		chk({24'h0, u_mem.dm[8'hf0]}, {24'h0, w2});
		chk({24'h0, u_mem.dm[8'h30]}, {24'h0, t[7:0]});
		chk({29'h0, pin_dir_sel_r}, 32'h0000_0005);
		chk({24'h0, pin_dir_data_r}, {24'h0, v});
		// Standby, wake, then a software reset into a tight loop at zero
		u_mem.pm[14] = 14'h0063;
		u_mem.pm[15] = 14'h0001;
		u_mem.pm[0] = 14'h2800;
		q_cyc = {2'h1, 2'h1, 2'h2};
		bus(1, 5'h00, 32'h0000_0001);
		repeat (10) @(posedge core_clk);
		chk({31'h0, sleep_r}, 32'h0000_0001);
		wake_pin <= 1;
		for (int i = 0; i < 300 && q_cyc.size() > 0; i++)
			@(posedge core_clk);
		chk(q_cyc.size(), 0);
		bus(1, 5'h00, 32'h0000_0000);
		bus(0, 5'h04, 32'h0000_0010);
		bus(0, 5'h08, 32'h0000_0000);
		bus(0, 5'h14, 32'h0000_0000);
		@(posedge core_clk);
		test_done();
	end
endmodule // core_control_indirect_op_decoder_bench
`default_nettype wire
